// ---- design/sor_pkg.sv ----
package sor_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [11:0] SOR_ECL_CTRL_OFS = 12'h000;
  localparam logic [11:0] SOR_FRONT_CTRL_OFS = 12'h004;
  localparam logic [11:0] SOR_TTL_CTRL_OFS = 12'h008;
  localparam logic [11:0] SOR_SOURCE_USE_OFS = 12'h00c;
  localparam logic [11:0] SOR_STATUS_OFS = 12'h010;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int SOR_ECL_EN_POS = 0;
  localparam int SOR_ECL_FEED_POS = 4;
  localparam int SOR_FRONT_EN_POS = 0;
  localparam int SOR_FRONT_FEED_POS = 4;
  localparam int SOR_TTL_EN_POS = 0;
  localparam int SOR_TTL_FEED_POS = 8;
  localparam int SOR_USE_ECL_POS = 0;
  localparam int SOR_USE_FRONT_POS = 4;
  localparam int SOR_USE_TTL_POS = 8;
  localparam int SOR_USE_EXTREF_POS = 16;
  localparam int SOR_ST_CONFLICT_POS = 0;
  localparam int SOR_ST_BUSY_POS = 1;
  localparam int SOR_ST_INIT_POS = 2;

  // ------------------------------------------------------------
  // Feed encodings
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SOR_ECL_FROM_TRIG,
    SOR_ECL_FROM_FRONT,
    SOR_ECL_FROM_REF
  } sor_ecl_feed_t;

  typedef enum logic [2:0] {
    SOR_FR_ARM,
    SOR_FR_READY_TRIG,
    SOR_FR_PREARM,
    SOR_FR_REF,
    SOR_FR_TRIG
  } sor_front_feed_t;

  typedef enum logic [0:0] {
    SOR_TTL_ARM,
    SOR_TTL_READY
  } sor_ttl_feed_t;

  // ------------------------------------------------------------
  // Reset values and timing
  // ------------------------------------------------------------
  localparam sor_ecl_feed_t SOR_ECL0_FEED_RST = SOR_ECL_FROM_TRIG;
  localparam sor_ecl_feed_t SOR_ECL1_FEED_RST = SOR_ECL_FROM_FRONT;
  localparam sor_front_feed_t SOR_FRONT_FEED_RST = SOR_FR_TRIG;
  localparam sor_ttl_feed_t SOR_TTL_FEED_RST = SOR_TTL_ARM;
  localparam int SOR_CLK_HZ = 40000000;
  localparam int SOR_PULSE_NS = 25;
  localparam int SOR_PULSE_RAW = (SOR_PULSE_NS * (SOR_CLK_HZ / 1000000)) / 1000;
  localparam int SOR_PULSE_CYC = (SOR_PULSE_RAW < 1) ? 1 : SOR_PULSE_RAW;
  localparam logic [3:0] SOR_PULSE_LEN = 4'(SOR_PULSE_CYC);

  // ------------------------------------------------------------
  // Sequencer events
  // ------------------------------------------------------------
  typedef struct packed {
    logic initiate;
    logic arm_event;
    logic arm_delay_done;
    logic cycle_done;
    logic prearm_met;
    logic segment_switch;
    logic meas_done;
    logic convert;
    logic readout;
  } sor_seq_ev_t;

endpackage

// ---- design/sor_pulse_gen.sv ----
`timescale 1ns/1ps
module sor_pulse_gen
  import sor_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fire,
  output logic pulse
);

  logic [3:0] count;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= 4'h0;
    else if (fire)
      count <= SOR_PULSE_LEN;
    else if (count != 4'h0)
      count <= count - 4'h1;
  end

  assign pulse = (count != 4'h0);

endmodule

// ---- design/sor_sync_output_router.sv ----
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module sor_sync_output_router
  import sor_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sor_seq_ev_t seq_ev,
  input wire logic initiated,
  input wire logic multi_arm_cycle,
  input wire logic ref_clk_level,
  output logic front_out,
  output logic front_oe,
  output logic [1:0] ecl_sync_line,
  output logic [1:0] ecl_sync_line_oe,
  output logic [7:0] ttl_sync_line_n,
  output logic [7:0] ttl_sync_line_oe
);

  // ------------------------------------------------------------
  // Configuration state
  // ------------------------------------------------------------
  logic [1:0] ecl_en;
  sor_ecl_feed_t ecl_feed [2];
  logic front_en;
  sor_front_feed_t front_feed;
  logic [7:0] ttl_en;
  sor_ttl_feed_t ttl_feed;
  logic [1:0] ecl_as_source;
  logic front_as_arm_source;
  logic [7:0] ttl_as_source;
  logic ext_ref;
  logic conflict;
  logic refused;

  logic wr_acc;
  logic rd_acc;
  logic mapped;
  logic [31:0] wd;

  function automatic logic is_ecl_feed(input logic [1:0] v);
    is_ecl_feed = (v <= 2'(SOR_ECL_FROM_REF));
  endfunction

  function automatic logic is_front_feed(input logic [2:0] v);
    is_front_feed = (v <= 3'(SOR_FR_TRIG));
  endfunction

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign wd = pwdata;
  assign mapped = (paddr == SOR_ECL_CTRL_OFS) || (paddr == SOR_FRONT_CTRL_OFS) ||
                  (paddr == SOR_TTL_CTRL_OFS) || (paddr == SOR_SOURCE_USE_OFS) ||
                  (paddr == SOR_STATUS_OFS);

  // ------------------------------------------------------------
  // APB slave handshake
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
    end
  end

  logic take;
  assign take = wr_acc && pready && mapped;

  logic cfg_write_ok;
  assign cfg_write_ok = take && !initiated;

  // ------------------------------------------------------------
  // Source usage owned by other subsystems
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ecl_as_source <= 2'h0;
      front_as_arm_source <= 1'b0;
      ttl_as_source <= 8'h00;
      ext_ref <= 1'b0;
    end
    else if (take && paddr == SOR_SOURCE_USE_OFS)
    begin
      ecl_as_source <= wd[SOR_USE_ECL_POS +: 2];
      front_as_arm_source <= wd[SOR_USE_FRONT_POS];
      ttl_as_source <= wd[SOR_USE_TTL_POS +: 8];
      ext_ref <= wd[SOR_USE_EXTREF_POS];
    end
  end

  // ------------------------------------------------------------
  // ECL configuration
  // ------------------------------------------------------------
  logic [1:0] ecl_req_en;
  logic [1:0] ecl_clash;
  assign ecl_req_en = wd[SOR_ECL_EN_POS +: 2];
  assign ecl_clash = ecl_req_en & ~ecl_en & ecl_as_source;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ecl_en <= 2'h0;
      ecl_feed[0] <= SOR_ECL0_FEED_RST;
      ecl_feed[1] <= SOR_ECL1_FEED_RST;
    end
    else if (cfg_write_ok && paddr == SOR_ECL_CTRL_OFS)
    begin
      for (int i = 0; i < 2; i++)
      begin
        if (!ecl_clash[i])
          ecl_en[i] <= ecl_req_en[i];
        if (is_ecl_feed(wd[SOR_ECL_FEED_POS + 4 * i +: 2]))
          ecl_feed[i] <= sor_ecl_feed_t'(wd[SOR_ECL_FEED_POS + 4 * i +: 2]);
      end
    end
  end

  // ------------------------------------------------------------
  // Front connector configuration
  // ------------------------------------------------------------
  logic front_clash;
  assign front_clash = wd[SOR_FRONT_EN_POS] && !front_en && front_as_arm_source;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      front_en <= 1'b0;
      front_feed <= SOR_FRONT_FEED_RST;
    end
    else if (cfg_write_ok && paddr == SOR_FRONT_CTRL_OFS)
    begin
      if (!front_clash)
        front_en <= wd[SOR_FRONT_EN_POS];
      if (is_front_feed(wd[SOR_FRONT_FEED_POS +: 3]))
        front_feed <= sor_front_feed_t'(wd[SOR_FRONT_FEED_POS +: 3]);
    end
  end

  // ------------------------------------------------------------
  // TTL configuration
  // ------------------------------------------------------------
  logic [7:0] ttl_req_en;
  logic [7:0] ttl_clash;
  assign ttl_req_en = wd[SOR_TTL_EN_POS +: 8];
  assign ttl_clash = ttl_req_en & ~ttl_en & ttl_as_source;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ttl_en <= 8'h00;
      ttl_feed <= SOR_TTL_FEED_RST;
    end
    else if (cfg_write_ok && paddr == SOR_TTL_CTRL_OFS)
    begin
      ttl_en <= (ttl_req_en & ~ttl_clash) | (ttl_en & ttl_clash);
      ttl_feed <= sor_ttl_feed_t'(wd[SOR_TTL_FEED_POS]);
    end
  end

  // ------------------------------------------------------------
  // Error flags (sticky; set wins over clear-on-read)
  // ------------------------------------------------------------
  logic any_clash;
  logic cfg_addr;
  logic status_read;
  assign cfg_addr = (paddr == SOR_ECL_CTRL_OFS) || (paddr == SOR_FRONT_CTRL_OFS) ||
                    (paddr == SOR_TTL_CTRL_OFS);
  assign any_clash = !initiated && (
                     (paddr == SOR_ECL_CTRL_OFS && ecl_clash != 2'h0) ||
                     (paddr == SOR_FRONT_CTRL_OFS && front_clash) ||
                     (paddr == SOR_TTL_CTRL_OFS && ttl_clash != 8'h00));
  assign status_read = rd_acc && pready && paddr == SOR_STATUS_OFS;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      conflict <= 1'b0;
      refused <= 1'b0;
    end
    else
    begin
      if (take && any_clash)
        conflict <= 1'b1;
      else if (status_read)
        conflict <= 1'b0;
      if (take && cfg_addr && initiated)
        refused <= 1'b1;
      else if (status_read)
        refused <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Sequencer level tracking
  // ------------------------------------------------------------
  logic arm_low;
  logic rft_low;
  logic prearm_low;
  logic ready_low;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      arm_low <= 1'b0;
      rft_low <= 1'b0;
      prearm_low <= 1'b0;
      ready_low <= 1'b0;
    end
    else
    begin
      // low from arm event to cycle done
      if (seq_ev.arm_event)
        arm_low <= 1'b1;
      else if (seq_ev.cycle_done)
        arm_low <= 1'b0;
      if (seq_ev.arm_delay_done)
        rft_low <= 1'b1;
      else if (seq_ev.cycle_done)
        rft_low <= 1'b0;
      // released by segment switch in a multi-arm cycle or initiation
      if (seq_ev.prearm_met)
        prearm_low <= 1'b1;
      else if (seq_ev.initiate || (multi_arm_cycle && seq_ev.segment_switch))
        prearm_low <= 1'b0;
      // low on initiation, high at segment switch in a multi-arm cycle or at measurement done
      if (seq_ev.initiate)
        ready_low <= 1'b1;
      else if (multi_arm_cycle && seq_ev.segment_switch)
        ready_low <= 1'b0;
      else if (seq_ev.meas_done)
        ready_low <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Trigger pulse and reference edge
  // ------------------------------------------------------------
  logic trig_pulse;
  logic ref_q;
  logic ref_out;

  sor_pulse_gen sor_pulse_gen_i (
    .pclk(pclk),
    .presetn(presetn),
    .fire(seq_ev.convert || seq_ev.readout),
    .pulse(trig_pulse)
  );

  // Registered copy keeps the reference sampling free of glitches
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ref_q <= 1'b0;
    else
      ref_q <= ref_clk_level;
  end

  // internal inverted so low on rising edge, external follows so low on falling edge
  assign ref_out = ext_ref ? ref_q : !ref_q;

  // ------------------------------------------------------------
  // Output drive
  // ------------------------------------------------------------
  logic next_front;
  always_comb
  begin
    case (front_feed)
      SOR_FR_ARM: next_front = !arm_low;
      SOR_FR_READY_TRIG: next_front = !rft_low;
      SOR_FR_PREARM: next_front = !prearm_low;
      SOR_FR_REF: next_front = ref_out;
      SOR_FR_TRIG: next_front = !trig_pulse;
      default: next_front = 1'b1;
    endcase
  end

  logic [1:0] next_ecl;
  logic [1:0] next_ecl_oe;
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      next_ecl_oe[i] = ecl_en[i];
      case (ecl_feed[i])
        SOR_ECL_FROM_TRIG: next_ecl[i] = trig_pulse;
        SOR_ECL_FROM_FRONT:
        begin
          next_ecl[i] = !next_front;
          next_ecl_oe[i] = ecl_en[i] && front_en;
        end
        SOR_ECL_FROM_REF: next_ecl[i] = !ref_out;
        default: next_ecl[i] = 1'b0;
      endcase
    end
  end

  logic next_ttl;
  assign next_ttl = (ttl_feed == SOR_TTL_READY) ? !ready_low : !arm_low;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      front_out <= 1'b1;
      front_oe <= 1'b0;
      ecl_sync_line <= 2'h0;
      ecl_sync_line_oe <= 2'h0;
      ttl_sync_line_n <= 8'hff;
      ttl_sync_line_oe <= 8'h00;
    end
    else
    begin
      front_out <= next_front;
      front_oe <= front_en;
      ecl_sync_line <= next_ecl;
      ecl_sync_line_oe <= next_ecl_oe;
      ttl_sync_line_n <= {8{next_ttl}};
      ttl_sync_line_oe <= ttl_en;
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel && !penable && !pwrite)
    begin
      prdata <= 32'h0;
      case (paddr)
        SOR_ECL_CTRL_OFS:
        begin
          prdata[SOR_ECL_EN_POS +: 2] <= ecl_en;
          prdata[SOR_ECL_FEED_POS +: 2] <= ecl_feed[0];
          prdata[SOR_ECL_FEED_POS + 4 +: 2] <= ecl_feed[1];
        end
        SOR_FRONT_CTRL_OFS:
        begin
          prdata[SOR_FRONT_EN_POS] <= front_en;
          prdata[SOR_FRONT_FEED_POS +: 3] <= front_feed;
        end
        SOR_TTL_CTRL_OFS:
        begin
          prdata[SOR_TTL_EN_POS +: 8] <= ttl_en;
          prdata[SOR_TTL_FEED_POS] <= ttl_feed;
        end
        SOR_SOURCE_USE_OFS:
        begin
          prdata[SOR_USE_ECL_POS +: 2] <= ecl_as_source;
          prdata[SOR_USE_FRONT_POS] <= front_as_arm_source;
          prdata[SOR_USE_TTL_POS +: 8] <= ttl_as_source;
          prdata[SOR_USE_EXTREF_POS] <= ext_ref;
        end
        SOR_STATUS_OFS:
        begin
          prdata[SOR_ST_CONFLICT_POS] <= conflict;
          prdata[SOR_ST_BUSY_POS] <= refused;
          prdata[SOR_ST_INIT_POS] <= initiated;
        end
        default: prdata <= 32'h0;
      endcase
    end
  end

endmodule

// ---- test/sor_chk.sv ----
`timescale 1ns/1ps
module sor_chk
  import sor_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire sor_seq_ev_t seq_ev,
  input wire logic initiated,
  input wire logic multi_arm_cycle,
  input wire logic ref_clk_level,
  input wire logic front_out,
  input wire logic front_oe,
  input wire logic [1:0] ecl_sync_line,
  input wire logic [1:0] ecl_sync_line_oe,
  input wire logic [7:0] ttl_sync_line_n,
  input wire logic [7:0] ttl_sync_line_oe
);
  // ------------------------------------------
  // Shadow of front feed and reference source
  // ------------------------------------------
  // Follows accepted writes only, so a refused write cannot move it
  logic [2:0] feed;
  logic ext_ref;
  logic wr;
  assign wr = psel && penable && pready && pwrite;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      feed <= SOR_FR_TRIG;
    else if (wr && !initiated && paddr == SOR_FRONT_CTRL_OFS && pwdata[6:4] < 3'h5)
      feed <= pwdata[6:4];
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ext_ref <= 1'b0;
    else if (wr && paddr == SOR_SOURCE_USE_OFS)
      ext_ref <= pwdata[SOR_USE_EXTREF_POS];
  end
  // Shared TTL feed, refused while initiated like the design
  logic tfeed;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tfeed <= SOR_TTL_FEED_RST;
    else if (wr && !initiated && paddr == SOR_TTL_CTRL_OFS)
      tfeed <= pwdata[SOR_TTL_FEED_POS];
  end
  // ------------------------------------------
  // Properties
  // ------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_fire;
    feed == SOR_FR_TRIG && (seq_ev.convert || seq_ev.readout)
    ##1 !(seq_ev.convert || seq_ev.readout);
  endsequence
  sequence s_ref_steady;
    feed == SOR_FR_REF && $past(feed, 3) == SOR_FR_REF && ext_ref == $past(ext_ref, 3);
  endsequence
  a_reset_quiet: assert property ($rose(presetn) |-> front_out && !front_oe
    && ecl_sync_line_oe == 2'h0 && ttl_sync_line_oe == 8'h00)
    else $error("outputs not quiet after reset");
  a_ttl_shared: assert property (ttl_sync_line_n == 8'h00 || ttl_sync_line_n == 8'hff)
    else $error("ttl lines disagree");
  a_refused_cfg: assert property (initiated && wr |=>
    ($stable(front_oe) && $stable(ecl_sync_line_oe) && $stable(ttl_sync_line_oe))[*3])
    else $error("enable moved while initiated");
  a_trig_pulse: assert property (s_fire |=> !front_out ##1 front_out)
    else $error("trigger pulse wrong");
  a_ref_copy: assert property (s_ref_steady |->
    front_out == ($past(ref_clk_level, 2) ^ !ext_ref))
    else $error("reference copy wrong");
  a_arm_drop: assert property (feed == SOR_FR_ARM && seq_ev.arm_event |-> ##2 !front_out)
    else $error("arm level late");
  a_ready_drop: assert property (feed == SOR_FR_READY_TRIG && seq_ev.arm_delay_done
    |-> ##2 !front_out)
    else $error("ready level late");
  a_prearm_drop: assert property (feed == SOR_FR_PREARM && seq_ev.prearm_met
    |-> ##2 !front_out)
    else $error("prearm level late");
  a_ttl_arm_drop: assert property (tfeed == 1'b0 && seq_ev.arm_event
    |-> ##2 ttl_sync_line_n == 8'h00)
    else $error("ttl arm level late");
  a_ttl_ready_drop: assert property (tfeed && seq_ev.initiate
    |-> ##2 ttl_sync_line_n == 8'h00)
    else $error("ttl ready level late");
endmodule

// ---- test/sor_bp_model.sv ----
`timescale 1ns/1ps
module sor_bp_model
(
  input wire logic front_out,
  input wire logic front_oe,
  input wire logic [1:0] ecl_sync_line,
  input wire logic [1:0] ecl_sync_line_oe,
  input wire logic [7:0] ttl_sync_line_n,
  input wire logic [7:0] ttl_sync_line_oe,
  output logic front_bus,
  output logic [1:0] ecl_bus,
  output logic [7:0] ttl_bus_n
);
  // Released lines go to their termination, never keep the last level
  assign front_bus = front_oe ? front_out : 1'b1;
  assign ecl_bus = ecl_sync_line & ecl_sync_line_oe;
  assign ttl_bus_n = ttl_sync_line_n | ~ttl_sync_line_oe;
endmodule

// ---- test/sync_output_router_tb_top.sv ----
`timescale 1ns/1ps
module sync_output_router_tb_top
  import sor_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic initiated = 1'b0, multi_arm_cycle = 1'b0, ref_clk_level = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  sor_seq_ev_t seq_ev = '0;
  logic pready, pslverr, front_out, front_oe, front_bus, err;
  logic [1:0] ecl_sync_line, ecl_sync_line_oe, ecl_bus;
  logic [7:0] ttl_sync_line_n, ttl_sync_line_oe, ttl_bus_n;
  int num_errors = 0, n_compared = 0;
  sor_sync_output_router sor_sync_output_router_i (.*);
  sor_bp_model sor_bp_model_i (.*);
  initial
  begin
    forever #12.5 pclk = ~pclk;
  end
  // ------------------------------------------
  // Shared tasks
  // ------------------------------------------
  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1)
    begin
      num_errors++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic st(input logic [31:0] exp);
    apb(1'b0, SOR_STATUS_OFS, 32'h0);
    chk("status", rd, exp);
  endtask
  task automatic ev(input logic [8:0] m);
    @(posedge pclk);
    seq_ev <= sor_seq_ev_t'(m);
    @(posedge pclk);
    seq_ev <= '0;
    repeat (3) @(posedge pclk);
  endtask
  // ------------------------------------------
  // Scenarios
  // ------------------------------------------
  // reset state
  task automatic t_reset;
    chk("oe", {front_oe, ecl_sync_line_oe, ttl_sync_line_oe}, 32'h0);
    chk("ttl", ttl_sync_line_n, 32'hff);
    apb(1'b0, SOR_FRONT_CTRL_OFS, 32'h0);
    chk("front ctrl", rd, 32'h40);
    apb(1'b0, SOR_ECL_CTRL_OFS, 32'h0);
    chk("ecl ctrl", rd, 32'h100);
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped", err, 32'h1);
    $display("reset test done");
  endtask
  task automatic t_ecl;
    apb(1'b1, SOR_ECL_CTRL_OFS, 32'h101);
    apb(1'b1, SOR_SOURCE_USE_OFS, 32'h2);
    apb(1'b1, SOR_ECL_CTRL_OFS, 32'h103);
    st(32'h1);
    chk("ecl oe", ecl_sync_line_oe, 32'h1);
    apb(1'b1, SOR_SOURCE_USE_OFS, 32'h0);
    apb(1'b1, SOR_ECL_CTRL_OFS, 32'h103);
    st(32'h0);
    chk("ecl oe", ecl_sync_line_oe, 32'h1);
    apb(1'b0, SOR_ECL_CTRL_OFS, 32'h0);
    chk("ecl ctrl", rd, 32'h103);
    $display("ecl test done");
  endtask
  task automatic t_front;
    apb(1'b1, SOR_SOURCE_USE_OFS, 32'h10);
    apb(1'b1, SOR_FRONT_CTRL_OFS, 32'h41);
    st(32'h1);
    chk("front oe", front_oe, 32'h0);
    apb(1'b1, SOR_SOURCE_USE_OFS, 32'h0);
    apb(1'b1, SOR_FRONT_CTRL_OFS, 32'h41);
    for (int i = 0; i < 2; i++)
    begin
      @(posedge pclk);
      seq_ev <= sor_seq_ev_t'(i ? 9'h001 : 9'h002);
      @(posedge pclk);
      seq_ev <= '0;
      @(posedge pclk);
      @(negedge pclk);
      chk("pulse", {front_bus, ecl_bus}, 32'h3);
      @(negedge pclk);
      chk("pulse end", {front_bus, ecl_bus}, 32'h4);
    end
    $display("front test done");
  endtask
  task automatic t_levels;
    logic [2:0] f [7] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2};
    logic [8:0] m [7] = '{9'h080, 9'h020, 9'h080, 9'h040, 9'h020, 9'h010, 9'h100};
    logic x [7] = '{1'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1};
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b1, SOR_FRONT_CTRL_OFS, {25'h0, f[i], 4'h1});
      ev(m[i]);
      chk("front level", front_bus, x[i]);
      chk("ecl1 level", ecl_bus[1], !x[i]);
    end
    st(32'h0);
    $display("level test done");
  endtask
  task automatic t_ref;
    apb(1'b1, SOR_FRONT_CTRL_OFS, 32'h31);
    ref_clk_level <= 1'b1;
    repeat (4) @(posedge pclk);
    chk("ref int", front_bus, 32'h0);
    apb(1'b1, SOR_SOURCE_USE_OFS, 32'h10000);
    repeat (4) @(posedge pclk);
    chk("ref ext", front_bus, 32'h1);
    repeat (9)
    begin
      @(posedge pclk);
      ref_clk_level <= ~ref_clk_level;
    end
    apb(1'b1, SOR_ECL_CTRL_OFS, 32'h123);
    repeat (2) @(posedge pclk);
    chk("ecl ref", {front_bus, ecl_bus}, 32'h3);
    apb(1'b1, SOR_SOURCE_USE_OFS, 32'h0);
    $display("ref test done");
  endtask
  task automatic t_ttl;
    logic [8:0] m [4] = '{9'h100, 9'h008, 9'h100, 9'h004};
    apb(1'b1, SOR_SOURCE_USE_OFS, 32'h800);
    apb(1'b1, SOR_TTL_CTRL_OFS, 32'h29);
    st(32'h1);
    chk("ttl oe", ttl_sync_line_oe, 32'h21);
    ev(9'h080);
    chk("ttl arm", ttl_bus_n, 32'hde);
    ev(9'h020);
    chk("ttl arm end", ttl_bus_n, 32'hff);
    apb(1'b1, SOR_TTL_CTRL_OFS, 32'h121);
    for (int i = 0; i < 4; i++)
    begin
      multi_arm_cycle <= (i < 2);
      ev(m[i]);
      chk("ttl ready", ttl_bus_n, i[0] ? 32'hff : 32'hde);
    end
    $display("ttl test done");
  endtask
  task automatic t_refused;
    initiated <= 1'b1;
    apb(1'b1, SOR_FRONT_CTRL_OFS, 32'h0);
    apb(1'b1, SOR_TTL_CTRL_OFS, 32'h0);
    apb(1'b0, SOR_FRONT_CTRL_OFS, 32'h0);
    chk("front kept", rd, 32'h31);
    st(32'h6);
    chk("ttl oe kept", ttl_sync_line_oe, 32'h21);
    initiated <= 1'b0;
    $display("refused test done");
  endtask
  task automatic t_rerun;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
  endtask
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ecl();
    t_front();
    t_levels();
    t_ref();
    t_ttl();
    t_refused();
    t_rerun();
    wrap_up();
  end
endmodule
bind sor_sync_output_router sor_chk sor_chk_i (.*);
